// [verif/wor_options_bench.sv]
// Self-checking bench for the write-once option block
`timescale 1ns/1ns
module wor_options_bench;
  // ----------------------------------------
  // Stimulus, design outputs and model state
  // ----------------------------------------
  reg        core_clk_i = '0, reset_i = '1, por_i = '1, pwrite_i = '0;
  reg        psel_i = '0, penable_i = '0, stop_opcode_i = '0;
  reg        stop_mode_i = '0, lv_reset_req_i = '0, stop_exit_by_lv_i = '0;
  reg [31:0] paddr_i = '0, pwdata_i = '0, d;
  wire       pready_o, pslverr_o, osc_pin_one_clock_o, osc_pin_two_crystal_o;
  wire       slow_crystal_select_o, monitor_crystal_range_o, clock_gen_run_o;
  wire       serial_port_clock_source_o, watchdog_enable_o, stop_execute_o;
  wire       low_voltage_power_on_o, low_voltage_run_in_stop_o;
  wire       low_voltage_reset_o, low_voltage_mode_5v_o, illegal_opcode_reset_o;
  wire [31:0] prdata_o;
  wire [12:0] stab_timeout_cycles_o, stop_recovery_cycles_o;
  wire [18:0] watchdog_timeout_cycles_o;
  wire [7:0] options_a_o, options_b_o;
  wire [1:0] options_locked_o;
  reg  [7:0] ma = '0, mb = '0;
  reg        la = '0, lb = '0, e;
  integer    miscompares = 0, checked = 0, r, i;
  wor_options DUT (.*);
  // System clock, 100 ns period
  always #50 core_clk_i = ~core_clk_i;
  // Compare, verdict and bus tasks
  task chk(input string n, input [31:0] x, y);
    checked++;
    if (x !== y) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, x, y);
    end
  endtask
  task close_out;
    if (miscompares == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task apb(input w, input [31:0] a, wd);
    integer n;
    @(posedge core_clk_i);
    psel_i <= 1'h1; pwrite_i <= w; paddr_i <= a; pwdata_i <= wd;
    @(posedge core_clk_i);
    penable_i <= 1'h1;
    n = 0;
    do begin @(posedge core_clk_i); n++; end
      while (pready_o !== 1'h1 && n < 16);
    if (n == 16) begin miscompares++; close_out; end
    d = prdata_o; e = pslverr_o;
    psel_i <= 1'h0; penable_i <= 1'h0;
  endtask
  task wr(input [31:0] a, wd);
    apb(1'h1, a, wd);
    if (a == 32'h1e && !lb) begin mb = wd[7:0]; lb = 1'h1; end
    if (a == 32'h1f && !la) begin ma = wd[7:0]; la = 1'h1; end
  endtask
  task rd(input [31:0] a);
    apb(1'h0, a, 32'h0);
    chk("rdata", a == 32'h1e ? mb : a == 32'h1f ? ma : 8'h0, d);
    chk("slverr", a != 32'h1e && a != 32'h1f, e);
  endtask
  task reset_dut(input p);
    @(posedge core_clk_i);
    reset_i <= 1'h1; por_i <= p;
    repeat (12) @(posedge core_clk_i);
    reset_i <= 1'h0; por_i <= 1'h0;
    la = 1'h0; lb = 1'h0; mb = 8'h0; ma = p ? 8'h0 : ma & 8'h08;
  endtask
  task dec;
    repeat (2) @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk("pins", {mb[4], mb[4] & mb[3], mb[2], mb[4] & mb[3], mb[0]},
      {osc_pin_one_clock_o, osc_pin_two_crystal_o, slow_crystal_select_o,
       monitor_crystal_range_o, serial_port_clock_source_o});
    chk("stab", mb[3] ? 4096 : 16, stab_timeout_cycles_o);
    chk("wdog", ma[7] ? 8176 : 262128, watchdog_timeout_cycles_o);
    chk("lvi", {!ma[0], !ma[4], ma[3]}, {watchdog_enable_o,
      low_voltage_power_on_o, low_voltage_mode_5v_o});
    chk("locked", {la, lb}, options_locked_o);
  endtask
  task ev(input [3:0] c);
    @(posedge core_clk_i);
    stop_mode_i <= c[0]; lv_reset_req_i <= c[1];
    stop_exit_by_lv_i <= c[2]; stop_opcode_i <= c[3];
    @(posedge core_clk_i);
    stop_opcode_i <= 1'h0;
    @(negedge core_clk_i);
    chk("run", !c[0] | mb[1], clock_gen_run_o);
    chk("lvrst", c[1] & !ma[5], low_voltage_reset_o);
    chk("lvstop", ma[6] & !ma[4], low_voltage_run_in_stop_o);
    chk("rec", ma[2] & !c[2] ? 32 : 4096, stop_recovery_cycles_o);
    chk("stop", {c[3] & ma[1], c[3] & !ma[1]},
      {stop_execute_o, illegal_opcode_reset_o});
  endtask
  // Rounds of reset, first write, refused rewrite and events
  initial begin
    void'($urandom(97224));
    for (r = 0; r < 4; r++) begin
      reset_dut(r != 2);
      rd(32'h1e);
      rd(32'h1f);
      rd(32'h20);
      // Short recovery is used in rounds 2 and 3, so keep the clock running
      wr(32'h1e, ($urandom & 32'h1f) | {r[1], 1'h0});
      d = $urandom;
      d[2:1] = r[1:0];
      wr(32'h1f, d);
      dec;
      wr(32'h1f, ~ma);
      wr(32'h1e, ~mb & 8'h1f);
      rd(32'h1f);
      rd(32'h1e);
      dec;
      for (i = 0; i < 16; i++) ev(i);
      ev(4'h0);
    end
    close_out;
  end
endmodule

// [verif/wor_options_sva.sv]
// Assertion checker for the write-once option block
`timescale 1ns/1ns
module wor_options_chk (
  input wire        core_clk_i,
  input wire        reset_i,
  input wire        stop_opcode_i,
  input wire        stop_mode_i,
  input wire        lv_reset_req_i,
  input wire        stop_exit_by_lv_i,
  input wire [7:0]  options_a_o,
  input wire [7:0]  options_b_o,
  input wire [1:0]  options_locked_o,
  input wire        osc_pin_two_crystal_o,
  input wire        clock_gen_run_o,
  input wire        low_voltage_reset_o,
  input wire        illegal_opcode_reset_o,
  input wire [12:0] stab_timeout_cycles_o,
  input wire [12:0] stop_recovery_cycles_o,
  input wire [18:0] watchdog_timeout_cycles_o
);
  // ----------------------------------------
  // Lock and decode checks, one cycle latency
  // ----------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  property p_hold; options_locked_o[1] |=> $stable(options_a_o); endproperty
  a_hold: assert property (p_hold) else $error("locked a changed");
  property p_xtal;
    osc_pin_two_crystal_o == $past(options_b_o[4] & options_b_o[3]);
  endproperty
  a_xtal: assert property (p_xtal) else $error("crystal pin");
  property p_stab; stab_timeout_cycles_o ==
    ($past(options_b_o[3]) ? 13'h1000 : 13'h010); endproperty
  a_stab: assert property (p_stab) else $error("stab count");
  property p_run;
    clock_gen_run_o == $past(!stop_mode_i | options_b_o[1]);
  endproperty
  a_run: assert property (p_run) else $error("clock run");
  property p_wdog; watchdog_timeout_cycles_o ==
    ($past(options_a_o[7]) ? 19'h01ff0 : 19'h3fff0); endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog count");
  property p_lvr;
    low_voltage_reset_o == $past(lv_reset_req_i & !options_a_o[5]);
  endproperty
  a_lvr: assert property (p_lvr) else $error("monitor reset");
  property p_rec; stop_recovery_cycles_o == ($past(options_a_o[2] &
    !stop_exit_by_lv_i) ? 13'h020 : 13'h1000); endproperty
  a_rec: assert property (p_rec) else $error("recovery");
  property p_ill;
    stop_opcode_i |=> illegal_opcode_reset_o == !$past(options_a_o[1]);
  endproperty
  a_ill: assert property (p_ill) else $error("illegal stop");
endmodule

bind wor_options wor_options_chk u_chk (.*);

// [verilog/wor_defines.vh]
// Offsets, bit positions, reset values and timing counts of the option block
`ifndef WOR_DEFINES_VH
`define WOR_DEFINES_VH

// Byte addresses of the two option registers (consecutive)
`define WOR_ADDR_B              8'h1e
`define WOR_ADDR_A              8'h1f
`define WOR_RESET_VAL           8'h00

// Fields of write_once_options_b
`define WOR_B_SERIAL_SRC        0
`define WOR_B_OSC_IN_STOP       1
`define WOR_B_EXT_SLOW          2
`define WOR_B_XTAL_EN           3
`define WOR_B_CLK_EN            4

// Fields of write_once_options_a
`define WOR_A_WDOG_DIS          0
`define WOR_A_STOP_EN           1
`define WOR_A_SHORT_REC         2
`define WOR_A_LV_MODE           3
`define WOR_A_LV_PWR_DIS        4
`define WOR_A_LV_RST_DIS        5
`define WOR_A_LV_IN_STOP        6
`define WOR_A_WDOG_RATE         7

// Timing counts in oscillator clock cycles
`define WOR_STAB_LONG           13'd4096
`define WOR_STAB_SHORT          13'd16
`define WOR_REC_LONG            13'd4096
`define WOR_REC_SHORT           13'd32
`define WOR_WDOG_SHORT          19'd8176
`define WOR_WDOG_LONG           19'd262128

`endif

// [verilog/wor_once_reg.v]
// One write-once byte register with reset value and write-lock tracking
`timescale 1ns/1ns
module wor_once_reg (
  input  wire       core_clk_i,
  input  wire       reset_i,
  input  wire       wr_i,
  input  wire [7:0] wdata_i,
  output reg  [7:0] value_o,
  output reg        locked_o
);

  // Accept the first write after reset, then freeze until reset
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      value_o  <= 8'h00;
      locked_o <= 1'b0;
    end else if (wr_i && !locked_o) begin
      value_o  <= wdata_i;
      locked_o <= 1'b1;
    end
  end

endmodule

// [verilog/wor_options.v]
// Write-once option register pair with decoded system option outputs
//
// Function
// - Accept one write per register after each reset, then hold value.
// - Reset clears all option bits except those with narrower reset.
// - Two consecutive byte addresses; reads have no side effects.
// - Clock pin enable turns oscillator pin one into clock input.
// - Crystal enable needs clock enable; both make pin two crystal pin.
// - Slow crystal bit selects slow range; monitor range follows pin two crystal.
// - Without crystal enable the monitor accepts the wide external range.
// - Stabilization timeout 4096 cycles with crystal enable set (even without clock enable), else 16.
// - Oscillator-in-stop keeps the clock generator running in stop; else it stops in stop mode.
// - Serial port clock: bus clock when set, oscillator clock else.
// - Watchdog rate picks 2^13-2^4 or 2^18-2^4 cycle timeout.
// - Monitor runs in stop only with its in-stop bit set and power enabled.
// - Low-voltage reset disable blocks monitor resets.
// - Power disable bit powers down the low-voltage monitor.
// - Mode bit picks 5 V or 3 V; only power-on reset clears.
// - Short recovery: 32 cycles when set, 4096 cycles when clear.
// - Stop exit by low-voltage reset always uses long recovery.
// - Stop enable clear makes stop an illegal opcode.
// - Watchdog disable bit disables the watchdog.
// - Disabled stop instruction raises an illegal-opcode reset.
`timescale 1ns/1ns
`include "wor_defines.vh"
module wor_options (
  input  wire        core_clk_i,
  input  wire        reset_i,
  input  wire        por_i,
  // APB slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [31:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output wire        pready_o,
  output wire        pslverr_o,
  output reg  [31:0] prdata_o,
  // Events from the rest of the chip
  input  wire        stop_opcode_i,
  input  wire        stop_mode_i,
  input  wire        lv_reset_req_i,
  input  wire        stop_exit_by_lv_i,
  // Decoded options
  output reg         osc_pin_one_clock_o,
  output reg         osc_pin_two_crystal_o,
  output reg         slow_crystal_select_o,
  output reg         monitor_crystal_range_o,
  output reg  [12:0] stab_timeout_cycles_o,
  output reg         clock_gen_run_o,
  output reg         serial_port_clock_source_o,
  output reg  [18:0] watchdog_timeout_cycles_o,
  output reg         watchdog_enable_o,
  output reg         low_voltage_power_on_o,
  output reg         low_voltage_run_in_stop_o,
  output reg         low_voltage_reset_o,
  output reg         low_voltage_mode_5v_o,
  output reg  [12:0] stop_recovery_cycles_o,
  output reg         stop_execute_o,
  output reg         illegal_opcode_reset_o,
  output wire [7:0]  options_a_o,
  output wire [7:0]  options_b_o,
  output wire [1:0]  options_locked_o
);

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire        acc_w;
  wire        hit_a_w;
  wire        hit_b_w;
  wire        wr_a_w;
  wire        wr_b_w;
  wire [7:0]  opt_a_w;
  wire [7:0]  opt_b_w;
  wire        lock_a_w;
  wire        lock_b_w;
  reg         mode_r;

  // Zero-wait access; unmapped addresses answer with an error
  assign acc_w     = psel_i && penable_i;
  assign hit_b_w   = (paddr_i == {24'h000000, `WOR_ADDR_B});
  assign hit_a_w   = (paddr_i == {24'h000000, `WOR_ADDR_A});
  assign pready_o  = 1'b1;
  assign pslverr_o = acc_w && !hit_a_w && !hit_b_w;
  assign wr_a_w    = acc_w && pwrite_i && hit_a_w;
  assign wr_b_w    = acc_w && pwrite_i && hit_b_w;

  // ------------------------------------------------------------
  // Write-once storage
  // ------------------------------------------------------------
  // Each register latches its first write and drops later ones
  wor_once_reg u_reg_a (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .wr_i       (wr_a_w),
    .wdata_i    (pwdata_i[7:0]),
    .value_o    (opt_a_w),
    .locked_o   (lock_a_w)
  );

  wor_once_reg u_reg_b (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .wr_i       (wr_b_w),
    .wdata_i    (pwdata_i[7:0]),
    .value_o    (opt_b_w),
    .locked_o   (lock_b_w)
  );

  // Voltage-mode bit: cleared only by power-on reset
  always @(posedge core_clk_i or posedge por_i) begin
    if (por_i) begin
      mode_r <= 1'b0;
    end else if (wr_a_w && !lock_a_w) begin
      mode_r <= pwdata_i[`WOR_A_LV_MODE];
    end
  end

  assign options_a_o      = {opt_a_w[7:4], mode_r, opt_a_w[2:0]};
  assign options_b_o      = opt_b_w;
  assign options_locked_o = {lock_a_w, lock_b_w};

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  // Registered read data, reads change no state
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata_o <= 32'h00000000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      if (paddr_i == {24'h000000, `WOR_ADDR_A}) begin
        prdata_o <= {24'h000000, options_a_o};
      end else if (paddr_i == {24'h000000, `WOR_ADDR_B}) begin
        prdata_o <= {24'h000000, options_b_o};
      end else begin
        prdata_o <= 32'h00000000;
      end
    end
  end

  // ------------------------------------------------------------
  // Option decode
  // ------------------------------------------------------------
  wire clk_en_w;
  wire xtal_en_w;
  wire lv_pwr_dis_w;
  wire stop_en_w;

  assign clk_en_w     = opt_b_w[`WOR_B_CLK_EN];
  assign xtal_en_w    = opt_b_w[`WOR_B_XTAL_EN];
  assign lv_pwr_dis_w = opt_a_w[`WOR_A_LV_PWR_DIS];
  assign stop_en_w    = opt_a_w[`WOR_A_STOP_EN];

  // Registered option outputs follow the stored bits
  always @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      osc_pin_one_clock_o        <= 1'b0;
      osc_pin_two_crystal_o      <= 1'b0;
      slow_crystal_select_o      <= 1'b0;
      monitor_crystal_range_o    <= 1'b0;
      stab_timeout_cycles_o      <= `WOR_STAB_SHORT;
      clock_gen_run_o            <= 1'b1;
      serial_port_clock_source_o <= 1'b0;
      watchdog_timeout_cycles_o  <= `WOR_WDOG_LONG;
      watchdog_enable_o          <= 1'b1;
      low_voltage_power_on_o     <= 1'b1;
      low_voltage_run_in_stop_o  <= 1'b0;
      low_voltage_reset_o        <= 1'b0;
      low_voltage_mode_5v_o      <= 1'b0;
      stop_recovery_cycles_o     <= `WOR_REC_LONG;
      stop_execute_o             <= 1'b0;
      illegal_opcode_reset_o     <= 1'b0;
    end else begin
      osc_pin_one_clock_o   <= clk_en_w;
      osc_pin_two_crystal_o <= clk_en_w && xtal_en_w;
      slow_crystal_select_o <= opt_b_w[`WOR_B_EXT_SLOW];
      // Crystal range only when the crystal is really enabled
      monitor_crystal_range_o <= clk_en_w && xtal_en_w;
      stab_timeout_cycles_o <= xtal_en_w ? `WOR_STAB_LONG
                                         : `WOR_STAB_SHORT;
      clock_gen_run_o <= !stop_mode_i ||
                         opt_b_w[`WOR_B_OSC_IN_STOP];
      serial_port_clock_source_o <= opt_b_w[`WOR_B_SERIAL_SRC];
      watchdog_timeout_cycles_o <= opt_a_w[`WOR_A_WDOG_RATE]
                                   ? `WOR_WDOG_SHORT
                                   : `WOR_WDOG_LONG;
      watchdog_enable_o <= !opt_a_w[`WOR_A_WDOG_DIS];
      low_voltage_power_on_o <= !lv_pwr_dis_w;
      low_voltage_run_in_stop_o <= opt_a_w[`WOR_A_LV_IN_STOP] &&
                                   !lv_pwr_dis_w;
      low_voltage_reset_o <= lv_reset_req_i &&
                             !opt_a_w[`WOR_A_LV_RST_DIS];
      low_voltage_mode_5v_o <= mode_r;
      // Low-voltage stop exit forces the long delay
      stop_recovery_cycles_o <= (opt_a_w[`WOR_A_SHORT_REC] &&
                                 !stop_exit_by_lv_i)
                                ? `WOR_REC_SHORT
                                : `WOR_REC_LONG;
      stop_execute_o <= stop_opcode_i && stop_en_w;
      illegal_opcode_reset_o <= stop_opcode_i && !stop_en_w;
    end
  end

endmodule
